// ---- core/ahf_axis_helper.sv ----
// per-axis feedforward bias, home edge and index search, forward soft limit
// How it works
// - accel gain register 0..8191 in quarter units, zero after reset
// - accel bias added while accelerating, subtracted while decelerating
// - accel bias magnitude clamped to the ten-volt code
// - accel gain written mid-move takes effect at the next move start
// - accel bias active in absolute, relative, increment, jog and pvt moves
// - accel bias off in contour, slave, linear and vector motion
// - edge search runs until home changes; direction from polarised start level
// - home transition found makes the motor decelerate to a stop
// - only a rising index edge triggers the index search
// - stage one jogs at jog speed until index rises, latches, stops
// - stage two reverses and moves to latched index at homing speed
// - completed index search redefines the axis position as zero
// - forward limit signed 32 bits, default 2147483647 disables it
// - exceeded limit during motion stops the axis; forward motion refused
// - limit trips when position reaches limit plus one
// - limit compared in encoder counts or microsteps for stepper axes
// - limit trip raises the limit event for the host handler
// - move started beyond the limit profiles a short move before tripping
// - velocity gain 0..8191 drives bias from sample-to-sample reference change
// - velocity bias also in contour and slave, gain*vel*1.22e-6*tm/1000
module ahf_axis_helper (
    input  wire logic               CORE_CLK_I,
    input  wire logic               RST_I,
    input  wire logic [7:0]         ADDR_I,
    input  wire logic [31:0]        WDATA_I,
    input  wire logic               WR_I,
    input  wire logic               RD_I,
    output logic      [31:0]        RDATA_O,
    input  wire ahf_pkg::ahf_prof_t PROFILE_I,
    input  wire logic               HOME_I,
    input  wire logic               INDEX_I,
    output logic      [15:0]        MOTOR_BIAS_O,
    output ahf_pkg::ahf_search_t    SEARCH_O,
    output logic                    STOP_REQ_O,
    output logic                    ZERO_POS_O,
    output logic                    FWD_INHIBIT_O,
    output logic                    LIMIT_EVENT_O,
    output logic                    SAMPLE_TICK_O
);
    typedef struct packed {
        logic [31:0]         rdata;
        logic [14:0]         accel_gain;
        logic [14:0]         accel_gain_act;
        logic [12:0]         vel_gain;
        logic [31:0]         fwd_limit;
        logic [31:0]         accel_rate;
        logic [31:0]         decel_rate;
        logic [15:0]         sample_time;
        logic [31:0]         jog_speed;
        logic [31:0]         homing_speed;
        logic [31:0]         search_speed;
        logic                home_pol;
        logic                stepper;
        logic                edge_armed;
        logic                index_armed;
        logic [23:0]         tick_cnt;
        logic                tick;
        logic                home_s1;
        logic                home_s2;
        logic                idx_s1;
        logic                idx_s2;
        logic                idx_prev;
        logic                idx_seen;
        logic                home_start;
        ahf_pkg::ahf_state_t state;
        logic [31:0]         index_latch;
        logic [31:0]         ref_prev;
        logic [15:0]         bias;
        ahf_pkg::ahf_search_t search;
        logic                stop_req;
        logic                zero_pos;
        logic                fwd_inhibit;
        logic                limit_event;
        logic                limit_tripped;
        logic [3:0]          grace;
    } ahf_regs_t;

    ahf_regs_t st_reg;
    ahf_regs_t st_next;

    // saturate a magnitude to the signed bias range
    function automatic logic signed [16:0] sat_bias(input logic [63:0] mag, input logic neg);
        logic [14:0] m;
        m = (|mag[63:15]) ? ahf_pkg::BIAS_MAX : mag[14:0];
        return neg ? -$signed({2'b00, m}) : $signed({2'b00, m});
    endfunction : sat_bias

    logic [31:0]         pos_sel;
    logic                beyond_limit;
    logic                accel_on;
    logic [31:0]         rate_sel;
    logic [31:0]         tm_sq;
    logic [94:0]         acc_prod;
    logic [94:0]         acc_mag;
    logic signed [32:0]  ref_delta;
    logic [32:0]         delta_mag;
    logic [60:0]         vel_prod;
    logic [60:0]         vel_mag;
    logic signed [16:0]  acc_bias;
    logic signed [16:0]  vel_bias;
    logic signed [17:0]  bias_sum;
    logic                home_level;
    logic                home_changed;
    logic                wr_cmd;

    always_comb begin
        pos_sel      = st_reg.stepper ? PROFILE_I.microstep_position
                                      : PROFILE_I.encoder_position;
        beyond_limit = $signed(pos_sel) > $signed(st_reg.fwd_limit);
        accel_on     = !PROFILE_I.slave && (PROFILE_I.mode inside {
            ahf_pkg::MODE_ABSOLUTE_MOVE, ahf_pkg::MODE_RELATIVE_MOVE,
            ahf_pkg::MODE_INCREMENT_MOVE, ahf_pkg::MODE_JOG, ahf_pkg::MODE_PVT});
        rate_sel     = PROFILE_I.decelerating ? st_reg.decel_rate : st_reg.accel_rate;
        tm_sq        = 32'(st_reg.sample_time) * 32'(st_reg.sample_time);
        acc_prod     = 95'(st_reg.accel_gain_act) * 95'(rate_sel) * 95'(tm_sq)
                       * 95'(ahf_pkg::ACC_K);
        acc_mag      = acc_prod >> ahf_pkg::ACC_SHIFT;
        if (accel_on && (PROFILE_I.accelerating || PROFILE_I.decelerating)) begin
            acc_bias = sat_bias(acc_mag[63:0] | {63'h0, |acc_mag[94:64]},
                                PROFILE_I.decelerating);
        end else begin
            acc_bias = '0;
        end
        ref_delta    = $signed({PROFILE_I.reference_position[31],
                                 PROFILE_I.reference_position})
                       - $signed({st_reg.ref_prev[31], st_reg.ref_prev});
        delta_mag    = ref_delta[32] ? 33'(-ref_delta) : 33'(ref_delta);
        vel_prod     = 61'(st_reg.vel_gain) * 61'(delta_mag) * 61'(ahf_pkg::VEL_K);
        vel_mag      = vel_prod >> ahf_pkg::VEL_SHIFT;
        vel_bias     = sat_bias({3'h0, vel_mag}, ref_delta[32]);
        bias_sum     = 18'(acc_bias) + 18'(vel_bias);
        home_level   = st_reg.home_s2 ^ st_reg.home_pol;
        home_changed = home_level != st_reg.home_start;
        wr_cmd       = WR_I && ADDR_I == ahf_pkg::OFS_COMMAND;
    end

    always_comb begin
        st_next             = st_reg;
        st_next.stop_req    = 1'b0;
        st_next.zero_pos    = 1'b0;
        st_next.limit_event = 1'b0;
        st_next.rdata       = 32'h0000_0000;
        // pin synchronisers
        st_next.home_s1     = HOME_I;
        st_next.home_s2     = st_reg.home_s1;
        st_next.idx_s1      = INDEX_I;
        st_next.idx_s2      = st_reg.idx_s1;
        st_next.idx_prev    = st_reg.idx_s2;
        // sample tick from the sample time in microseconds
        st_next.tick        = 1'b0;
        if (st_reg.tick_cnt == 24'h000000) begin
            st_next.tick     = 1'b1;
            st_next.tick_cnt = 24'(32'(st_reg.sample_time) * ahf_pkg::CYC_PER_US - 1);
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt - 24'h000001;
        end

        // register writes
        if (WR_I) begin
            unique case (ADDR_I)
                ahf_pkg::OFS_ACCEL_GAIN:   st_next.accel_gain =
                    (WDATA_I > 32'(ahf_pkg::ACCEL_GAIN_MAX)) ? ahf_pkg::ACCEL_GAIN_MAX
                                                              : WDATA_I[14:0];
                ahf_pkg::OFS_VEL_GAIN:     st_next.vel_gain =
                    (WDATA_I > 32'(ahf_pkg::VEL_GAIN_MAX)) ? ahf_pkg::VEL_GAIN_MAX
                                                            : WDATA_I[12:0];
                ahf_pkg::OFS_FWD_LIMIT:    st_next.fwd_limit    = WDATA_I;
                ahf_pkg::OFS_ACCEL_RATE:   st_next.accel_rate   = WDATA_I;
                ahf_pkg::OFS_DECEL_RATE:   st_next.decel_rate   = WDATA_I;
                ahf_pkg::OFS_SAMPLE_TIME: begin
                    st_next.sample_time = |WDATA_I[15:0] ? WDATA_I[15:0] : 16'h0001;
                    st_next.tick_cnt = 24'(32'(st_next.sample_time) * ahf_pkg::CYC_PER_US - 1);
                end
                ahf_pkg::OFS_JOG_SPEED:    st_next.jog_speed    = WDATA_I;
                ahf_pkg::OFS_HOMING_SPEED: st_next.homing_speed = WDATA_I;
                ahf_pkg::OFS_SEARCH_SPEED: st_next.search_speed = WDATA_I;
                ahf_pkg::OFS_CONFIG: begin
                    st_next.home_pol = WDATA_I[ahf_pkg::CFG_HOME_POL_BIT];
                    st_next.stepper  = WDATA_I[ahf_pkg::CFG_STEPPER_BIT];
                end
                default: ;
            endcase
        end
        // selecting a search only arms it
        if (wr_cmd && st_reg.state == ahf_pkg::S_IDLE) begin
            if (WDATA_I[ahf_pkg::CMD_EDGE_BIT]) begin
                st_next.edge_armed  = 1'b1;
                st_next.index_armed = 1'b0;
            end else if (WDATA_I[ahf_pkg::CMD_INDEX_BIT]) begin
                st_next.index_armed = 1'b1;
                st_next.edge_armed  = 1'b0;
            end
        end

        // register reads, data in the next cycle
        if (RD_I) begin
            unique case (ADDR_I)
                ahf_pkg::OFS_ACCEL_GAIN:   st_next.rdata = 32'(st_reg.accel_gain);
                ahf_pkg::OFS_VEL_GAIN:     st_next.rdata = 32'(st_reg.vel_gain);
                ahf_pkg::OFS_FWD_LIMIT:    st_next.rdata = st_reg.fwd_limit;
                ahf_pkg::OFS_ACCEL_RATE:   st_next.rdata = st_reg.accel_rate;
                ahf_pkg::OFS_DECEL_RATE:   st_next.rdata = st_reg.decel_rate;
                ahf_pkg::OFS_SAMPLE_TIME:  st_next.rdata = 32'(st_reg.sample_time);
                ahf_pkg::OFS_JOG_SPEED:    st_next.rdata = st_reg.jog_speed;
                ahf_pkg::OFS_HOMING_SPEED: st_next.rdata = st_reg.homing_speed;
                ahf_pkg::OFS_SEARCH_SPEED: st_next.rdata = st_reg.search_speed;
                ahf_pkg::OFS_CONFIG:       st_next.rdata = {30'h0, st_reg.stepper,
                                                            st_reg.home_pol};
                ahf_pkg::OFS_STATUS:       st_next.rdata = {24'h0, st_reg.limit_tripped,
                    st_reg.fwd_inhibit, st_reg.index_armed, st_reg.edge_armed,
                    1'b0, 3'(st_reg.state)};
                ahf_pkg::OFS_INDEX_LATCH:  st_next.rdata = st_reg.index_latch;
                default:                   st_next.rdata = 32'h0000_0000;
            endcase
        end

        // new gain only at a move start
        if (PROFILE_I.move_start) begin
            st_next.accel_gain_act = st_reg.accel_gain;
            st_next.grace = beyond_limit ? ahf_pkg::LIMIT_GRACE_TICKS : 4'h0;
            st_next.limit_tripped = 1'b0;
        end

        // sticky index edge; a new edge beats the tick clear
        if (st_reg.tick) begin
            st_next.idx_seen = 1'b0;
        end
        if (st_reg.idx_s2 && !st_reg.idx_prev) begin
            st_next.idx_seen = 1'b1;
        end

        if (st_reg.tick) begin
            st_next.ref_prev    = PROFILE_I.reference_position;
            st_next.bias        = (bias_sum > 18'sd32767) ? 16'h7FFF :
                                  (bias_sum < -18'sd32767) ? 16'h8001 : bias_sum[15:0];
            st_next.fwd_inhibit = beyond_limit;
            if (st_reg.grace != 4'h0) begin
                st_next.grace = st_reg.grace - 4'h1;
            end else if (PROFILE_I.in_motion && beyond_limit && !st_reg.limit_tripped) begin
                st_next.limit_tripped = 1'b1;
                st_next.stop_req      = 1'b1;
                st_next.limit_event   = 1'b1;
            end
            if (!beyond_limit) begin
                st_next.limit_tripped = 1'b0;
            end

            unique case (st_reg.state)
                ahf_pkg::S_IDLE: begin
                    if (st_reg.edge_armed && st_reg.search.run) begin
                        st_next.state = ahf_pkg::S_EDGE_RUN;
                    end
                end
                ahf_pkg::S_EDGE_RUN: begin
                    if (home_changed) begin
                        st_next.search.run = 1'b0;
                        st_next.stop_req   = 1'b1;
                        st_next.state      = ahf_pkg::S_EDGE_STOP;
                    end
                end
                ahf_pkg::S_EDGE_STOP: begin
                    if (!PROFILE_I.in_motion) begin
                        st_next.state = ahf_pkg::S_IDLE;
                    end
                end
                ahf_pkg::S_IDX_JOG: begin
                    if (st_reg.idx_seen) begin
                        st_next.index_latch = pos_sel;
                        st_next.search.run  = 1'b0;
                        st_next.stop_req    = 1'b1;
                        st_next.state       = ahf_pkg::S_IDX_STOP;
                    end
                end
                ahf_pkg::S_IDX_STOP: begin
                    if (!PROFILE_I.in_motion) begin
                        st_next.search.go_to   = 1'b1;
                        st_next.search.forward = !st_reg.search.forward;
                        st_next.search.speed   = st_reg.homing_speed;
                        st_next.search.target  = st_reg.index_latch;
                        st_next.state          = ahf_pkg::S_IDX_RETURN;
                    end
                end
                ahf_pkg::S_IDX_RETURN: begin
                    if (!PROFILE_I.in_motion && pos_sel == st_reg.index_latch) begin
                        st_next.search.go_to = 1'b0;
                        st_next.zero_pos     = 1'b1;
                        st_next.state        = ahf_pkg::S_IDLE;
                    end
                end
            endcase
        end

        // begin starts an armed search
        if (wr_cmd && WDATA_I[ahf_pkg::CMD_BEGIN_BIT] && st_reg.state == ahf_pkg::S_IDLE
            && (st_reg.edge_armed || st_reg.index_armed)) begin
            st_next.edge_armed  = 1'b0;
            st_next.index_armed = 1'b0;
            st_next.search.run  = 1'b1;
            st_next.search.go_to = 1'b0;
            if (st_reg.edge_armed) begin
                st_next.home_start     = home_level;
                st_next.search.forward = !home_level;
                st_next.search.speed   = st_reg.search_speed;
                st_next.state          = ahf_pkg::S_EDGE_RUN;
            end else begin
                st_next.idx_seen       = 1'b0;
                st_next.search.forward = !st_reg.jog_speed[31];
                st_next.search.speed   = st_reg.jog_speed[31] ? -st_reg.jog_speed
                                                              : st_reg.jog_speed;
                st_next.state          = ahf_pkg::S_IDX_JOG;
            end
        end
        // no forward search travel past the limit
        if (beyond_limit && st_next.search.forward && st_next.search.run) begin
            st_next.search.run = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_reg             <= '0;
            st_reg.accel_gain  <= ahf_pkg::RST_ACCEL_GAIN;
            st_reg.vel_gain    <= ahf_pkg::RST_VEL_GAIN;
            st_reg.fwd_limit   <= ahf_pkg::RST_FWD_LIMIT;
            st_reg.sample_time <= ahf_pkg::RST_SAMPLE_TIME;
            st_reg.state       <= ahf_pkg::S_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA_O       = st_reg.rdata;
    assign MOTOR_BIAS_O  = st_reg.bias;
    assign SEARCH_O      = st_reg.search;
    assign STOP_REQ_O    = st_reg.stop_req;
    assign ZERO_POS_O    = st_reg.zero_pos;
    assign FWD_INHIBIT_O = st_reg.fwd_inhibit;
    assign LIMIT_EVENT_O = st_reg.limit_event;
    assign SAMPLE_TICK_O = st_reg.tick;
endmodule : ahf_axis_helper

// ---- include/ahf_pkg.sv ----
// shared constants, enumerations and carriers of the axis feedforward and homing helper
package ahf_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_ACCEL_GAIN   = 8'h00;
    localparam logic [7:0] OFS_VEL_GAIN     = 8'h04;
    localparam logic [7:0] OFS_FWD_LIMIT    = 8'h08;
    localparam logic [7:0] OFS_ACCEL_RATE   = 8'h0C;
    localparam logic [7:0] OFS_DECEL_RATE   = 8'h10;
    localparam logic [7:0] OFS_SAMPLE_TIME  = 8'h14;
    localparam logic [7:0] OFS_JOG_SPEED    = 8'h18;
    localparam logic [7:0] OFS_HOMING_SPEED = 8'h1C;
    localparam logic [7:0] OFS_SEARCH_SPEED = 8'h20;
    localparam logic [7:0] OFS_CONFIG       = 8'h24;
    localparam logic [7:0] OFS_COMMAND      = 8'h28;
    localparam logic [7:0] OFS_STATUS       = 8'h2C;
    localparam logic [7:0] OFS_INDEX_LATCH  = 8'h30;
    // field positions
    localparam int CFG_HOME_POL_BIT = 0;
    localparam int CFG_STEPPER_BIT  = 1;
    localparam int CMD_EDGE_BIT     = 0;
    localparam int CMD_INDEX_BIT    = 1;
    localparam int CMD_BEGIN_BIT    = 2;
    // values after reset
    localparam logic [14:0] RST_ACCEL_GAIN  = 15'h0000;
    localparam logic [12:0] RST_VEL_GAIN    = 13'h0000;
    localparam logic [31:0] RST_FWD_LIMIT   = 32'h7FFFFFFF;
    localparam logic [15:0] RST_SAMPLE_TIME = 16'h03E8;
    // accel gain held in quarter units: 8191 whole units
    localparam logic [14:0] ACCEL_GAIN_MAX  = 15'h7FFC;
    localparam logic [12:0] VEL_GAIN_MAX    = 13'h1FFF;
    // bias output: signed 16-bit code, full scale equals ten volts
    localparam real         BIAS_FULL_VOLTS = 10.0;
    localparam logic [14:0] BIAS_MAX        = 15'h7FFF;
    // accel bias = q*rate*tm^2*ACC_K / 2^ACC_SHIFT (q quarter units, tm in us)
    localparam logic [15:0] ACC_K           = 16'h871B;
    localparam int          ACC_SHIFT       = 48;
    // velocity bias = gain*delta_ref*VEL_K / 2^VEL_SHIFT (tm cancels out)
    localparam logic [14:0] VEL_K           = 15'h3FF6;
    localparam int          VEL_SHIFT       = 12;
    // timing
    localparam real         CLK_MHZ         = 100.0;
    localparam int          CYC_PER_US      = 100;
    localparam logic [3:0]  LIMIT_GRACE_TICKS = 4'h4;

    typedef enum logic [2:0] {
        MODE_ABSOLUTE_MOVE, MODE_RELATIVE_MOVE, MODE_INCREMENT_MOVE, MODE_JOG,
        MODE_PVT, MODE_CONTOUR, MODE_LINEAR_INTERP, MODE_VECTOR
    } ahf_mode_t;

    typedef enum logic [2:0] {
        S_IDLE, S_EDGE_RUN, S_EDGE_STOP, S_IDX_JOG, S_IDX_STOP, S_IDX_RETURN
    } ahf_state_t;

    // what the profiler reports every clock
    typedef struct packed {
        logic        move_start;
        logic        in_motion;
        logic        accelerating;
        logic        decelerating;
        logic        slave;
        ahf_mode_t   mode;
        logic [31:0] reference_position;
        logic [31:0] encoder_position;
        logic [31:0] microstep_position;
    } ahf_prof_t;

    // what the search asks of the profiler
    typedef struct packed {
        logic        run;
        logic        forward;
        logic        go_to;
        logic [31:0] speed;
        logic [31:0] target;
    } ahf_search_t;
endpackage : ahf_pkg

// ---- bench/ahf_axis_helper_monitor.sv ----
// concurrent checks on the ports of the axis helper
module ahf_axis_helper_monitor (
    input wire logic                 CORE_CLK_I,
    input wire logic                 RST_I,
    input wire logic [7:0]           ADDR_I,
    input wire logic [31:0]          WDATA_I,
    input wire logic                 WR_I,
    input wire logic                 RD_I,
    input wire logic [31:0]          RDATA_O,
    input wire logic [15:0]          MOTOR_BIAS_O,
    input wire ahf_pkg::ahf_search_t SEARCH_O,
    input wire logic                 STOP_REQ_O,
    input wire logic                 ZERO_POS_O,
    input wire logic                 LIMIT_EVENT_O,
    input wire logic                 SAMPLE_TICK_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_stop_once;
        !SEARCH_O.run && STOP_REQ_O ##1 !STOP_REQ_O;
    endsequence
    AST_RDATA_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("stray read data");
    AST_RUN_STOP: assert property ($fell(SEARCH_O.run) |-> s_stop_once)
        else $error("no stop pulse");
    AST_RUN_BEGIN: assert property ($rose(SEARCH_O.run) |-> $past(WR_I) && $past(WDATA_I[2])
        && $past(ADDR_I) == ahf_pkg::OFS_COMMAND)
        else $error("run without begin");
    AST_ZERO_PULSE: assert property (ZERO_POS_O |-> $past(SEARCH_O.go_to) ##1 !ZERO_POS_O)
        else $error("bad zero pulse");
    AST_LIMIT_STOP: assert property (LIMIT_EVENT_O |-> STOP_REQ_O ##1 !LIMIT_EVENT_O)
        else $error("event without stop");
    AST_BIAS_TICK: assert property ($changed(MOTOR_BIAS_O) |-> SAMPLE_TICK_O
        || $past(SAMPLE_TICK_O) || $past(SAMPLE_TICK_O, 2))
        else $error("bias off tick");
    AST_BIAS_CLAMP: assert property (MOTOR_BIAS_O != 16'h8000)
        else $error("bias overrange");
    AST_TICK_GAP: assert property (SAMPLE_TICK_O |=> !SAMPLE_TICK_O [*8])
        else $error("ticks too close");
endmodule : ahf_axis_helper_monitor
bind ahf_axis_helper ahf_axis_helper_monitor mon_u (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .MOTOR_BIAS_O(MOTOR_BIAS_O), .SEARCH_O(SEARCH_O), .STOP_REQ_O(STOP_REQ_O),
    .ZERO_POS_O(ZERO_POS_O), .LIMIT_EVENT_O(LIMIT_EVENT_O), .SAMPLE_TICK_O(SAMPLE_TICK_O));

// ---- bench/ahf_partner.sv ----
// behavioural amplifier, encoder, home switch and index line of one axis
module ahf_partner (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 tick_i,
    input  wire logic                 stop_i,
    input  wire logic                 zero_i,
    input  wire ahf_pkg::ahf_search_t search_i,
    input  wire ahf_pkg::ahf_prof_t   ctl_i,
    output ahf_pkg::ahf_prof_t        prof_o,
    output logic                      home_o,
    output logic                      index_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] pos_reg;
    logic [31:0] step;
    logic        halt_reg;
    logic        coast_reg;
    assign step = search_i.forward ? search_i.speed : -search_i.speed;
    assign home_o = $signed(pos_reg) >= 500;
    assign index_o = pos_reg[9:0] >= 10'd900;
    always_comb begin
        prof_o = ctl_i;
        prof_o.in_motion = search_i.run | coast_reg | (ctl_i.in_motion & ~halt_reg)
            | (search_i.go_to && pos_reg != search_i.target);
        prof_o.reference_position = pos_reg;
        prof_o.encoder_position = pos_reg;
        prof_o.microstep_position = pos_reg;
    end
    // coasts one tick after a search stops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pos_reg <= 32'h0;
            halt_reg <= 1'b0;
            coast_reg <= 1'b0;
        end else begin
            if (stop_i) halt_reg <= 1'b1;
            else if (ctl_i.move_start) halt_reg <= 1'b0;
            if (zero_i) pos_reg <= 32'h0;
            else if (tick_i) begin
                coast_reg <= search_i.run;
                if (search_i.go_to && $signed(search_i.target - pos_reg) <= $signed(search_i.speed)
                    && $signed(pos_reg - search_i.target) <= $signed(search_i.speed))
                    pos_reg <= search_i.target;
                else if (search_i.go_to || search_i.run) pos_reg <= pos_reg + step;
                else if (ctl_i.in_motion && !halt_reg) pos_reg <= pos_reg + ctl_i.reference_position;
            end
        end
    end
endmodule : ahf_partner

// ---- bench/test_ahf_axis_helper.sv ----
// self-checking bench of the axis helper
module test_ahf_axis_helper;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} ahf_row_t;
    logic                 clk, rst, wr, rd, home, index, stop, zero, lim, tick, inh;
    logic [7:0]           addr;
    logic [31:0]          wdata, rdata;
    logic [15:0]          bias;
    ahf_pkg::ahf_prof_t   ctl, prof;
    ahf_pkg::ahf_search_t srch;
    int                   err_count, n_tests, k;
    ahf_row_t rows [8] = '{'{0, 8'h00, 0, 32'h0}, '{0, 8'h04, 0, 32'h0},
        '{0, 8'h08, 0, 32'h7FFFFFFF}, '{0, 8'h14, 0, 32'h3E8}, '{1, 8'h3C, 32'h5, 32'h0},
        '{1, 8'h00, 32'hFFFF, 32'h7FFC}, '{1, 8'h04, 32'hFFFF, 32'h1FFF}, '{1, 8'h14, 0, 32'h1}};
    ahf_axis_helper dut_u (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PROFILE_I(prof), .HOME_I(home), .INDEX_I(index),
        .MOTOR_BIAS_O(bias), .SEARCH_O(srch), .STOP_REQ_O(stop), .ZERO_POS_O(zero),
        .FWD_INHIBIT_O(inh), .LIMIT_EVENT_O(lim), .SAMPLE_TICK_O(tick));
    ahf_partner part_u (.clk_i(clk), .rst_i(rst), .tick_i(tick), .stop_i(stop), .zero_i(zero),
        .search_i(srch), .ctl_i(ctl), .prof_o(prof), .home_o(home), .index_o(index));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task results();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task tk(input int n);
        repeat (n) @(posedge tick);
        repeat (4) @(posedge clk);
        #1;
    endtask : tk
    task wt(input logic [3:0] sel);
        for (k = 0; k < 20000; k++) begin
            @(posedge clk);
            #1;
            if (|(sel & {srch.go_to, lim, zero, stop})) break;
        end
        chk(32'(k < 20000), 32'h1);
    endtask : wt
    initial begin
        #1_000_000;
        err_count++;
        results();
    end
    initial begin
        {rst, wr, rd, addr, wdata, ctl, err_count, n_tests} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            @(posedge clk);
            {rd, addr} <= {1'b1, rows[i].a};
            @(posedge clk);
            rd <= 1'b0;
            #1 chk(rdata, rows[i].e);
        end
        wr_reg(8'h04, 32'hA);
        ctl.mode <= ahf_pkg::MODE_CONTOUR;
        {ctl.in_motion, ctl.reference_position} <= {1'b1, 32'd200};
        tk(3);
        chk({16'h0, bias}, 32'h1F3B);
        ctl.reference_position <= 32'h0;
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h14, 32'h32);
        wr_reg(8'h0C, 32'h0BEBC200);
        wr_reg(8'h10, 32'h0BEBC200);
        wr_reg(8'h00, 32'h28);
        {ctl.mode, ctl.accelerating, ctl.move_start} <= {ahf_pkg::MODE_JOG, 2'b11};
        @(posedge clk);
        ctl.move_start <= 1'b0;
        wr_reg(8'h00, 32'h50);
        tk(2);
        chk({16'h0, bias}, 32'h0999);
        {ctl.accelerating, ctl.decelerating} <= 2'b01;
        for (int m = 0; m < 8; m++) begin
            ctl.mode <= ahf_pkg::ahf_mode_t'(m);
            tk(1);
            chk({16'h0, bias}, m < 5 ? 32'hF667 : 32'h0);
        end
        {ctl.mode, ctl.slave} <= {ahf_pkg::MODE_JOG, 1'b1};
        tk(1);
        chk({16'h0, bias}, 32'h0);
        {ctl.decelerating, ctl.slave, ctl.in_motion} <= 3'b000;
        wr_reg(8'h14, 32'h1);
        wr_reg(8'h20, 32'h64);
        wr_reg(8'h28, 32'h1);
        repeat (300) @(posedge clk);
        chk(32'(srch.run), 32'h0);
        wr_reg(8'h28, 32'h4);
        #1;
        chk({srch.run, srch.forward, srch.speed[29:0]}, 32'h80000064);
        wt(4'h1);
        chk(prof.encoder_position, 32'h12C);
        repeat (300) @(posedge clk);
        wr_reg(8'h18, 32'h64);
        wr_reg(8'h1C, 32'h1E);
        wr_reg(8'h28, 32'h2);
        wr_reg(8'h28, 32'h4);
        wt(4'h8);
        chk({srch.forward, srch.speed[30:0]}, 32'h1E);
        chk(srch.target, 32'h384);
        wt(4'h2);
        chk(prof.encoder_position, 32'h384);
        wr_reg(8'h08, 32'h3E8);
        {ctl.in_motion, ctl.reference_position, ctl.move_start} <= {1'b1, 32'd500, 1'b1};
        @(posedge clk);
        ctl.move_start <= 1'b0;
        wt(4'h4);
        chk({prof.encoder_position[30:0], inh}, 32'hFA1);
        results();
    end
endmodule : test_ahf_axis_helper
